// ### logic/sss_sequencer.sv
`timescale 1ns/1ps
module sss_sequencer #(
  parameter int SETTLE_CYCLES = sss_pkg::SETTLE_CYC
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_timer_compare_interrupt,
  input  wire logic                      i_adc_done,
  input  wire logic [sss_pkg::ADC_W-1:0] i_adc_result,
  input  wire logic                      i_cpu_lamp_on,
  input  wire logic                      i_cpu_resume_stop,
  output logic                           o_amp_power_out,
  output logic                           o_photodiode_power_out,
  output logic                           o_ir_emitter_out_n,
  output logic                           o_status_lamp_out_n,
  output logic                           o_adc_start,
  output logic [3:0]                     o_adc_channel,
  output logic                           o_adc_ref_sel,
  output logic                           o_sequencer_wake_interrupt,
  output logic                           o_cpu_run
);

  // sequencer state; every output below is read straight off one of these flops
  sss_pkg::sss_state_t       state_reg;
  sss_pkg::sss_state_t       state_next;
  sss_pkg::sss_sensor_t      sens_reg;
  sss_pkg::sss_sensor_t      sens_next;
  sss_pkg::sss_adc_req_t     adc_reg;
  sss_pkg::sss_adc_req_t     adc_next;
  logic [sss_pkg::CNT_W-1:0] cnt_reg;
  logic [sss_pkg::CNT_W-1:0] cnt_next;
  logic                      wake_reg;
  logic                      wake_next;
  logic                      lamp_reg;
  logic                      lamp_next;
  logic                      fire_reg;
  logic                      fire_next;
  logic                      run_reg;
  logic                      run_next;

  // checker helper: cycles the sensor has been powered with the emitter still dark
  logic [sss_pkg::CNT_W-1:0] dark_reg;
  logic [sss_pkg::CNT_W-1:0] dark_next;

  always_comb begin
    state_next = state_reg;
    sens_next  = sens_reg;
    adc_next   = adc_reg;
    // start is a one-cycle strobe; channel and reference stay put after it
    adc_next.start = 1'h0;
    cnt_next   = cnt_reg;
    wake_next  = 1'h0;
    fire_next  = fire_reg;
    lamp_next  = lamp_reg;
    case (state_reg)
      sss_pkg::SSS_STOP: begin
        sens_next = sss_pkg::SENS_IDLE;
        if (i_timer_compare_interrupt) begin
          state_next = sss_pkg::SSS_POWER;
        end
      end
      sss_pkg::SSS_POWER: begin
        sens_next.amp_power        = 1'h1;
        sens_next.photodiode_power = 1'h1;
        cnt_next   = sss_pkg::CNT_W'(SETTLE_CYCLES - 1);
        state_next = sss_pkg::SSS_SETTLE;
      end
      sss_pkg::SSS_SETTLE: begin
        if (cnt_reg == '0) begin
          state_next = sss_pkg::SSS_EMIT;
        end else begin
          cnt_next = cnt_reg - 1'h1;
        end
      end
      sss_pkg::SSS_EMIT: begin
        sens_next.ir_emitter_n = sss_pkg::LOW_ON;
        adc_next.start   = 1'h1;
        adc_next.channel = sss_pkg::ADC_CH_SENSOR;
        adc_next.ref_sel = sss_pkg::ADC_REF_SUPPLY;
        state_next = sss_pkg::SSS_CONV;
      end
      sss_pkg::SSS_CONV: begin
        if (i_adc_done) begin
          fire_next  = (i_adc_result > sss_pkg::THRESHOLD);
          state_next = sss_pkg::SSS_SENSOFF;
        end
      end
      sss_pkg::SSS_SENSOFF: begin
        sens_next.amp_power        = 1'h0;
        sens_next.photodiode_power = 1'h0;
        state_next = sss_pkg::SSS_EMITOFF;
      end
      sss_pkg::SSS_EMITOFF: begin
        sens_next.ir_emitter_n = sss_pkg::LOW_OFF;
        if (fire_reg) begin
          wake_next  = 1'h1;
          state_next = sss_pkg::SSS_RUN;
        end else begin
          state_next = sss_pkg::SSS_STOP;
        end
      end
      sss_pkg::SSS_RUN: begin
        sens_next = sss_pkg::SENS_IDLE;
        if (i_cpu_resume_stop) begin
          state_next = sss_pkg::SSS_STOP;
        end
      end
      default: begin
        state_next = sss_pkg::SSS_STOP;
        sens_next  = sss_pkg::SENS_IDLE;
      end
    endcase
    // registered so the run flag leaves the block glitch free
    run_next = (state_next == sss_pkg::SSS_RUN);
    // lamp follows the cpu only while it runs; it keeps its level once the cpu stops again
    if (run_reg) begin
      lamp_next = i_cpu_lamp_on ? sss_pkg::LOW_ON : sss_pkg::LOW_OFF;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= sss_pkg::SSS_STOP;
      sens_reg  <= sss_pkg::SENS_IDLE;
      adc_reg   <= sss_pkg::ADC_IDLE;
      cnt_reg   <= '0;
      wake_reg  <= 1'h0;
      lamp_reg  <= sss_pkg::LOW_OFF;
      fire_reg  <= 1'h0;
      run_reg   <= 1'h0;
    end else begin
      state_reg <= state_next;
      sens_reg  <= sens_next;
      adc_reg   <= adc_next;
      cnt_reg   <= cnt_next;
      wake_reg  <= wake_next;
      lamp_reg  <= lamp_next;
      fire_reg  <= fire_next;
      run_reg   <= run_next;
    end
  end

  always_comb begin
    dark_next = dark_reg;
    if (!sens_reg.amp_power) begin
      dark_next = '0;
    end else if (sens_reg.ir_emitter_n) begin
      dark_next = dark_reg + 1'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dark_reg <= '0;
    end else begin
      dark_reg <= dark_next;
    end
  end

  assign o_amp_power_out            = sens_reg.amp_power;
  assign o_photodiode_power_out     = sens_reg.photodiode_power;
  assign o_ir_emitter_out_n         = sens_reg.ir_emitter_n;
  assign o_status_lamp_out_n        = lamp_reg;
  assign o_adc_start                = adc_reg.start;
  assign o_adc_channel              = adc_reg.channel;
  assign o_adc_ref_sel              = adc_reg.ref_sel;
  assign o_sequencer_wake_interrupt = wake_reg;
  assign o_cpu_run                  = run_reg;

  sequence launch_s;
    (state_reg == sss_pkg::SSS_STOP) && i_timer_compare_interrupt;
  endsequence

  sequence powered_s;
    o_amp_power_out && o_photodiode_power_out;
  endsequence

  sequence judged_s;
    (state_reg == sss_pkg::SSS_CONV) && i_adc_done;
  endsequence

  timer_launch_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    launch_s |=> ##1 powered_s)
    else $error("sensor not powered after launch");

  sensor_cpu_excl_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_amp_power_out |-> !o_cpu_run)
    else $error("sensor powered while cpu runs");

  power_first_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_amp_power_out) |-> o_photodiode_power_out && o_ir_emitter_out_n)
    else $error("power order wrong");

  settle_wait_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_amp_power_out) |-> o_ir_emitter_out_n [*8])
    else $error("emitter on before settling");

  settle_length_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $fell(o_ir_emitter_out_n) |-> dark_reg == SETTLE_CYCLES + 1)
    else $error("settling interval wrong length");

  conv_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_adc_start |-> !o_ir_emitter_out_n && o_amp_power_out)
    else $error("conversion without emitter");

  start_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_adc_start |=> !o_adc_start)
    else $error("conversion start longer than one cycle");

  off_order_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $fell(o_amp_power_out) |-> !o_ir_emitter_out_n ##1 o_ir_emitter_out_n)
    else $error("sensor off order wrong");

  adc_setup_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_adc_start |-> o_adc_channel == sss_pkg::ADC_CH_SENSOR && o_adc_ref_sel == sss_pkg::ADC_REF_SUPPLY)
    else $error("wrong adc channel or reference");

  wake_judge_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    judged_s |-> ##3 (o_sequencer_wake_interrupt == ($past(i_adc_result, 3) > sss_pkg::THRESHOLD)))
    else $error("wake decision wrong");

  run_judge_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    judged_s |-> ##3 (o_cpu_run == ($past(i_adc_result, 3) > sss_pkg::THRESHOLD)))
    else $error("run decision wrong");

  idle_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state_reg == sss_pkg::SSS_STOP && $past(state_reg) == sss_pkg::SSS_STOP)
      |-> !o_amp_power_out && !o_photodiode_power_out && o_ir_emitter_out_n)
    else $error("sensor on while idle");

  lamp_owner_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $changed(o_status_lamp_out_n) |-> $past(o_cpu_run))
    else $error("lamp changed without cpu");
endmodule // sss_sequencer

// ### logic/sss_pkg.sv
package sss_pkg;
  localparam int          ADC_W          = 12;
  localparam logic [11:0] THRESHOLD      = 12'hE8B;
  localparam int          CLK_MHZ        = 100;
  localparam int          SETTLE_US      = 20;
  localparam int          SETTLE_CYC     = SETTLE_US * CLK_MHZ;
  localparam int          CNT_W          = 16;
  localparam logic [3:0]  ADC_CH_SENSOR  = 4'h2;
  localparam logic        ADC_REF_SUPPLY = 1'h0;
  localparam logic        LOW_ON         = 1'h0;
  localparam logic        LOW_OFF        = 1'h1;

  typedef enum logic [7:0] {
    SSS_STOP   = 8'h01,
    SSS_POWER  = 8'h02,
    SSS_SETTLE = 8'h04,
    SSS_EMIT   = 8'h08,
    SSS_CONV   = 8'h10,
    SSS_SENSOFF= 8'h20,
    SSS_EMITOFF= 8'h40,
    SSS_RUN    = 8'h80
  } sss_state_t;

  typedef struct packed {
    logic       amp_power;
    logic       photodiode_power;
    logic       ir_emitter_n;
  } sss_sensor_t;

  typedef struct packed {
    logic       start;
    logic [3:0] channel;
    logic       ref_sel;
  } sss_adc_req_t;

  // values after reset; the sensor value is also restored between launches, the adc value only at reset
  localparam sss_sensor_t  SENS_IDLE = '{amp_power: 1'h0, photodiode_power: 1'h0, ir_emitter_n: LOW_OFF};
  localparam sss_adc_req_t ADC_IDLE  = '{start: 1'h0, channel: 4'h0, ref_sel: 1'h0};
endpackage

// ### testbench/sss_sensor_model.sv
`timescale 1ns/1ps
module sss_sensor_model #(
  parameter int LAT = 3
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_amp_power_out,
  input  wire logic        i_photodiode_power_out,
  input  wire logic        i_ir_emitter_out_n,
  input  wire logic        i_adc_start,
  input  wire logic [3:0]  i_adc_channel,
  input  wire logic        i_adc_ref_sel,
  input  wire logic [11:0] i_smoke_level,
  output logic             o_adc_done,
  output logic [11:0]      o_adc_result
);
  int cnt;
  initial begin
    cnt = 0;
    o_adc_done = 1'h0;
    o_adc_result = 12'hAAA;
  end
  // result toggles outside done so a late sample never sees a stale value
  always @(posedge i_ref_clk) begin
    o_adc_done <= 1'h0;
    o_adc_result <= ~o_adc_result;
    if (i_adc_start)
      cnt <= LAT;
    else if (cnt > 0)
      cnt <= cnt - 1;
    if (cnt == 1) begin
      o_adc_done <= 1'h1;
      // an unpowered or dark sensor reads as zero
      o_adc_result <= (i_amp_power_out && i_photodiode_power_out && !i_ir_emitter_out_n &&
                       i_adc_channel == sss_pkg::ADC_CH_SENSOR &&
                       i_adc_ref_sel == sss_pkg::ADC_REF_SUPPLY) ? i_smoke_level : 12'h000;
    end
  end
endmodule // sss_sensor_model

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int SET   = 10;
  // about 80 cycles are needed; the ceiling leaves ample margin
  localparam int LIMIT = 2000;
  logic        clk    = 1'h0;
  logic        rst_n  = 1'h0;
  logic        tmr    = 1'h0;
  logic        lamp   = 1'h0;
  logic        resume = 1'h0;
  logic [11:0] lvl    = 12'h000;
  logic        done;
  logic [11:0] res;
  logic        amp;
  logic        pd;
  logic        ir_n;
  logic        lamp_n;
  logic        st;
  logic [3:0]  ch;
  logic        ref_s;
  logic        wake;
  logic        run;
  int          mismatches = 0;
  int          n_tests    = 0;
  int          cycles     = 0;
  always #5 clk = ~clk;
  sss_sequencer #(.SETTLE_CYCLES(SET)) sss_sequencer_inst (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_timer_compare_interrupt(tmr), .i_adc_done(done), .i_adc_result(res), .i_cpu_lamp_on(lamp),
    .i_cpu_resume_stop(resume), .o_amp_power_out(amp), .o_photodiode_power_out(pd),
    .o_ir_emitter_out_n(ir_n), .o_status_lamp_out_n(lamp_n), .o_adc_start(st), .o_adc_channel(ch),
    .o_adc_ref_sel(ref_s), .o_sequencer_wake_interrupt(wake), .o_cpu_run(run));
  sss_sensor_model sss_sensor_model_inst (.i_ref_clk(clk), .i_amp_power_out(amp), .i_photodiode_power_out(pd),
    .i_ir_emitter_out_n(ir_n), .i_adc_start(st), .i_adc_channel(ch), .i_adc_ref_sel(ref_s),
    .i_smoke_level(lvl), .o_adc_done(done), .o_adc_result(res));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic idle_check();
    chk({10'h0, amp, pd, ir_n, lamp_n, wake, run}, 16'h000C);
  endtask
  task automatic power_up();
    repeat (4) @(negedge clk);
    idle_check();
    chk({11'h0, st, ch, ref_s}, 16'h0000);
    rst_n = 1'h1;
    @(negedge clk);
  endtask
  // one full timer launch; fire says whether the level should wake the cpu
  task automatic sense(input logic [11:0] level, input logic fire);
    int n;
    lvl = level;
    tmr = 1'h1;
    @(negedge clk);
    tmr = 1'h0;
    n = 0;
    while (amp !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0, pd}, 16'h0001);
    chk(16'(n), 16'h0001);
    n = 0;
    // a second launch while busy must be ignored, else the settle count grows
    while (ir_n !== 1'h0 && n < SET + 20) begin
      chk({15'h0, st}, 16'h0000);
      tmr = (n == 2);
      @(negedge clk);
      n++;
    end
    tmr = 1'h0;
    // settle counts SET cycles, then one more cycle to light the emitter
    chk(16'(n), 16'(SET + 1));
    chk({10'h0, st, ch, ref_s}, {10'h0, 1'h1, sss_pkg::ADC_CH_SENSOR, sss_pkg::ADC_REF_SUPPLY});
    @(negedge clk);
    chk({14'h0, st, ir_n}, 16'h0000);
    n = 0;
    while (amp !== 1'h0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk({14'h0, pd, ir_n}, 16'h0000);
    @(negedge clk);
    chk({13'h0, ir_n, wake, run}, {13'h0, 1'h1, fire, fire});
  endtask
  task automatic lamp_test();
    lamp = 1'h1;
    repeat (2) @(negedge clk);
    chk({15'h0, lamp_n}, {15'h0, sss_pkg::LOW_ON});
    lamp = 1'h0;
    resume = 1'h1;
    repeat (2) @(negedge clk);
    resume = 1'h0;
    chk({15'h0, run}, 16'h0000);
    idle_check();
    lamp = 1'h1;
    repeat (2) @(negedge clk);
    lamp = 1'h0;
    chk({15'h0, lamp_n}, {15'h0, sss_pkg::LOW_OFF});
  endtask
  // reset in mid-sequence must drop every sensor output at once
  task automatic reset_mid();
    int n;
    tmr = 1'h1;
    @(negedge clk);
    tmr = 1'h0;
    n = 0;
    while (amp !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    rst_n = 1'h0;
    @(negedge clk);
    idle_check();
    chk({11'h0, st, ch, ref_s}, 16'h0000);
    rst_n = 1'h1;
    @(negedge clk);
    idle_check();
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > LIMIT) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    power_up();
    sense(sss_pkg::THRESHOLD, 1'h0);
    idle_check();
    sense(sss_pkg::THRESHOLD + 12'h001, 1'h1);
    lamp_test();
    reset_mid();
    sense(12'hFFF, 1'h1);
    repeat (3) @(negedge clk);
    chk({15'h0, wake}, 16'h0000);
    close_out();
  end
endmodule // testbench
